// *** design/otp_cmd_engine.sv ***
`timescale 1ns/100ps
`include "otp_regs.svh"

// Overview of operation
// - memory commands only after reset and bypass
// - all crcs use x8+x5+x4+1
// - page read command, address low then high
// - send crc over command and address
// - page read: data to page end, crc
// - then next page, fresh crc, until last
// - field read: data to memory end, no page crc
// - field end: crc over all bytes sent
// - after field crc, ones until reset
// - reset ends read; aborted read no crc
// - bytes travel lsb first both ways
// - write command, address, then address crc
// - eight data bytes to buffer, then crc
// - program pulse ands buffer into segment
// - reset ignored during program pulse
// - after programming return first byte of segment
// - device never judges crcs, just continues
// - unprogrammed memory reads all ones
// - protected page never programmed, still readable
module otp_cmd_engine
   import otp_pkg::*;
#(
   parameter int unsigned PROG_CYC   = `OTP_PROG_MIN_US * `OTP_CLK_MHZ,
   parameter int unsigned MEM_BYTES  = `OTP_MEM_BYTES,
   parameter int unsigned PAGE_BYTES = `OTP_PAGE_BYTES,
   parameter int unsigned SEG_BYTES  = `OTP_SEG_BYTES
) (
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   // slot front end
   input  wire logic                         link_reset,
   input  wire logic                         bit_strobe,
   input  wire logic                         bit_in,
   input  wire logic                         prog_pulse,
   // page write protection
   input  wire logic [MEM_BYTES/PAGE_BYTES-1:0] page_wp,
   // answers to the host
   output logic                              data_out,
   output logic                              device_answer_pulse
);

   // -------------------------------------------------------------------------
   // derived sizes
   // -------------------------------------------------------------------------
   localparam int unsigned AW    = $clog2(MEM_BYTES);
   localparam int unsigned PW    = $clog2(PAGE_BYTES);
   localparam int unsigned SW    = $clog2(SEG_BYTES);
   localparam int unsigned PCW   = $clog2(PROG_CYC + 1);
   localparam int unsigned ANS_C = `OTP_ANS_CYC;
   localparam int unsigned ACW   = $clog2(ANS_C + 1);

   // -------------------------------------------------------------------------
   // state and storage
   // -------------------------------------------------------------------------
   otp_state_e         state_r;
   otp_mode_e          mode_r;
   logic [AW-1:0]      addr_r;
   logic [2:0]         bit_cnt_r;
   logic [7:0]         rx_sh_r;
   logic [7:0]         tx_sh_r;
   logic [SW-1:0]      ptr_r;
   logic [PCW-1:0]     prog_cnt_r;
   logic               prog_done_r;
   logic [ACW-1:0]     ans_cnt_r;
   logic               ans_r;
   logic [7:0]         mem [MEM_BYTES];
   logic [7:0]         wbuf [SEG_BYTES];
   logic [7:0]         prog_byte [SEG_BYTES];

   // -------------------------------------------------------------------------
   // decode of the current slot
   // -------------------------------------------------------------------------
   logic               rst_take;
   logic               byte_done;
   logic [7:0]         rx_byte;
   logic [AW-1:0]      addr_inc;
   logic [AW-1:0]      seg_base;
   logic               page_end;
   logic               field_end;
   logic               is_rx;
   logic               is_data_tx;
   logic               prog_commit;
   logic               crc_clr;
   logic               crc_en;
   logic               crc_bit;
   logic [7:0]         crc_r;
   logic [7:0]         crc_nxt;

   // reset pulse is refused only while the program pulse is on
   assign rst_take    = link_reset && !(state_r == OTP_PROG_WAIT && prog_pulse);
   assign byte_done   = bit_strobe && (bit_cnt_r == 3'h7);
   assign rx_byte     = {bit_in, rx_sh_r[7:1]};
   assign addr_inc    = addr_r + 1'b1;
   assign seg_base    = {addr_r[AW-1:SW], {SW{1'b0}}};
   assign page_end    = (addr_r[PW-1:0] == {PW{1'b1}});
   assign field_end   = (addr_r == AW'(MEM_BYTES - 1));
   assign is_rx       = (state_r == OTP_ROMCMD) || (state_r == OTP_MEMCMD) ||
                        (state_r == OTP_ADDR_LO) || (state_r == OTP_ADDR_HI) ||
                        (state_r == OTP_WR_DATA) || (state_r == OTP_PROG_CMD);
   assign is_data_tx  = (state_r == OTP_RD_DATA);
   assign prog_commit = (state_r == OTP_PROG_WAIT) && prog_pulse && !prog_done_r &&
                        (prog_cnt_r == PCW'(PROG_CYC - 1));

   // crc feed: received command, address and write data, sent read data
   always_comb begin
      crc_en  = 1'b0;
      crc_bit = 1'b0;
      crc_clr = rst_take;
      case (state_r)
         OTP_MEMCMD, OTP_ADDR_LO, OTP_ADDR_HI, OTP_WR_DATA: begin
            crc_en  = bit_strobe;
            crc_bit = bit_in;
         end
         OTP_RD_DATA: begin
            crc_en  = bit_strobe;
            crc_bit = tx_sh_r[0];
         end
         default: begin
            crc_en  = 1'b0;
         end
      endcase
      if (byte_done) begin
         case (state_r)
            OTP_ROMCMD: crc_clr = 1'b1;
            OTP_CRC_TX: crc_clr = 1'b1;
            OTP_RD_CRC: crc_clr = 1'b1;
            default:    crc_clr = crc_clr;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // crc generator
   // -------------------------------------------------------------------------
   otp_crc8 u_crc (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .clr     (crc_clr),
      .en      (crc_en),
      .bit_in  (crc_bit),
      .crc_r   (crc_r),
      .crc_nxt (crc_nxt)
   );

   // -------------------------------------------------------------------------
   // receive shifter and bit counter
   // -------------------------------------------------------------------------
   // bits enter at the top so the first one ends in bit 0
   always_ff @(posedge ref_clk) begin
      if (!rst_n || rst_take) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r   <= 8'h00;
      end else if (bit_strobe) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_sh_r   <= rx_byte;
      end
   end

   // -------------------------------------------------------------------------
   // sequence state machine
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r <= OTP_IDLE;
         mode_r  <= OTP_MODE_PAGE;
         addr_r  <= '0;
         tx_sh_r <= `OTP_ERASED;
      end else if (rst_take) begin
         state_r <= OTP_ROMCMD;
         mode_r  <= OTP_MODE_PAGE;
         tx_sh_r <= `OTP_ERASED;
      end else if (prog_commit) begin
         state_r <= OTP_PROG_WAIT;
      end else if (state_r == OTP_PROG_WAIT && prog_done_r && !prog_pulse) begin
         state_r <= OTP_VERIFY;
         tx_sh_r <= mem[addr_r];
      end else if (bit_strobe) begin
         // outgoing bit leaves at bit 0, ones refill the top
         if (!is_rx) begin
            tx_sh_r <= {1'b1, tx_sh_r[7:1]};
         end
         if (byte_done) begin
            case (state_r)
               OTP_ROMCMD: begin
                  state_r <= (rx_byte == `OTP_CMD_BYPASS) ? OTP_MEMCMD : OTP_IDLE;
               end
               OTP_MEMCMD: begin
                  state_r <= OTP_ADDR_LO;
                  case (rx_byte)
                     `OTP_CMD_RD_PAGE:  mode_r <= OTP_MODE_PAGE;
                     `OTP_CMD_RD_FIELD: mode_r <= OTP_MODE_FIELD;
                     `OTP_CMD_WRITE:    mode_r <= OTP_MODE_WRITE;
                     default:           state_r <= OTP_IDLE;
                  endcase
               end
               OTP_ADDR_LO: begin
                  addr_r  <= rx_byte[AW-1:0];
                  state_r <= OTP_ADDR_HI;
               end
               OTP_ADDR_HI: begin
                  // high address byte only feeds the crc
                  if (mode_r == OTP_MODE_WRITE) begin
                     addr_r <= seg_base;
                  end
                  tx_sh_r <= crc_nxt;
                  state_r <= OTP_CRC_TX;
               end
               OTP_CRC_TX: begin
                  // no crc check here, the host decides
                  if (mode_r == OTP_MODE_WRITE) begin
                     state_r <= OTP_WR_DATA;
                  end else begin
                     tx_sh_r <= mem[addr_r];
                     state_r <= OTP_RD_DATA;
                  end
               end
               OTP_RD_DATA: begin
                  if ((mode_r == OTP_MODE_PAGE && page_end) || field_end) begin
                     tx_sh_r <= crc_nxt;
                     state_r <= OTP_RD_CRC;
                  end else begin
                     addr_r  <= addr_inc;
                     tx_sh_r <= mem[addr_inc];
                  end
               end
               OTP_RD_CRC: begin
                  if (mode_r == OTP_MODE_PAGE && !field_end) begin
                     addr_r  <= addr_inc;
                     tx_sh_r <= mem[addr_inc];
                     state_r <= OTP_RD_DATA;
                  end else begin
                     state_r <= OTP_ONES;
                  end
               end
               OTP_WR_DATA: begin
                  if (ptr_r == SW'(SEG_BYTES - 1)) begin
                     tx_sh_r <= crc_nxt;
                     state_r <= OTP_WR_CRC;
                  end
               end
               OTP_WR_CRC: begin
                  state_r <= OTP_PROG_CMD;
               end
               OTP_PROG_CMD: begin
                  state_r <= (rx_byte == `OTP_CMD_PROG) ? OTP_PROG_WAIT : OTP_IDLE;
               end
               OTP_VERIFY: begin
                  state_r <= OTP_ONES;
               end
               default: begin
                  state_r <= state_r;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // ram buffer fill
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n || rst_take) begin
         ptr_r <= '0;
      end else if (byte_done && state_r == OTP_WR_DATA) begin
         wbuf[ptr_r] <= rx_byte;
         ptr_r       <= ptr_r + 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // program pulse timing
   // -------------------------------------------------------------------------
   // the segment is written once the pulse has lasted its minimum time
   always_ff @(posedge ref_clk) begin
      if (!rst_n || state_r != OTP_PROG_WAIT) begin
         prog_cnt_r  <= '0;
         prog_done_r <= 1'b0;
      end else if (prog_commit) begin
         prog_done_r <= 1'b1;
      end else if (prog_pulse && !prog_done_r) begin
         prog_cnt_r  <= prog_cnt_r + 1'b1;
      end else if (!prog_pulse && !prog_done_r) begin
         prog_cnt_r  <= '0;
      end
   end

   // -------------------------------------------------------------------------
   // programmed values, one per segment byte
   // -------------------------------------------------------------------------
   for (genvar g = 0; g < SEG_BYTES; g++) begin : g_prog
      assign prog_byte[g] = mem[seg_base + AW'(g)] & wbuf[g];
   end

   // -------------------------------------------------------------------------
   // otp array
   // -------------------------------------------------------------------------
   // fresh array reads as ones, a protected page keeps its contents
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] <= `OTP_ERASED;
         end
      end else if (prog_commit && !page_wp[seg_base[AW-1:PW]]) begin
         for (int i = 0; i < SEG_BYTES; i++) begin
            mem[seg_base + AW'(i)] <= prog_byte[i];
         end
      end
   end

   // -------------------------------------------------------------------------
   // answer pulse after a reset pulse
   // -------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ans_cnt_r <= '0;
         ans_r     <= 1'b0;
      end else if (rst_take) begin
         ans_cnt_r <= ACW'(ANS_C);
         ans_r     <= 1'b0;
      end else if (ans_cnt_r != '0) begin
         ans_cnt_r <= ans_cnt_r - 1'b1;
         ans_r     <= !link_reset;
      end else begin
         ans_r     <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   assign data_out            = tx_sh_r[0];   // one means release the line
   assign device_answer_pulse = ans_r;

endmodule // otp_cmd_engine

// *** design/otp_regs.svh ***
`ifndef OTP_REGS_SVH
`define OTP_REGS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define OTP_CLK_MHZ       25
`define OTP_PROG_MIN_US   2500
`define OTP_ANS_US        120
`define OTP_ANS_CYC       (`OTP_ANS_US * `OTP_CLK_MHZ)

// ----------------------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------------------
`define OTP_MEM_BYTES     128
`define OTP_PAGE_BYTES    32
`define OTP_SEG_BYTES     8
`define OTP_ERASED        8'hff

// ----------------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------------
`define OTP_CMD_BYPASS    8'hcc
`define OTP_CMD_RD_PAGE   8'hc3
`define OTP_CMD_RD_FIELD  8'hf0
`define OTP_CMD_WRITE     8'h0f
`define OTP_CMD_PROG      8'h5a

// ----------------------------------------------------------------------------
// crc generator
// ----------------------------------------------------------------------------
`define OTP_CRC_POLY      8'h8c
`define OTP_CRC_INIT      8'h00

`endif

// *** design/otp_pkg.sv ***
package otp_pkg;

   // -------------------------------------------------------------------------
   // sequence states, gray coded in the order listed
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      OTP_IDLE      = 4'h0,
      OTP_ROMCMD    = 4'h1,
      OTP_MEMCMD    = 4'h3,
      OTP_ADDR_LO   = 4'h2,
      OTP_ADDR_HI   = 4'h6,
      OTP_CRC_TX    = 4'h7,
      OTP_RD_DATA   = 4'h5,
      OTP_RD_CRC    = 4'h4,
      OTP_WR_DATA   = 4'hc,
      OTP_WR_CRC    = 4'hd,
      OTP_PROG_CMD  = 4'hf,
      OTP_PROG_WAIT = 4'he,
      OTP_VERIFY    = 4'ha,
      OTP_ONES      = 4'hb
   } otp_state_e;

   // -------------------------------------------------------------------------
   // memory command selected after the bypass command
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      OTP_MODE_PAGE  = 2'h0,
      OTP_MODE_FIELD = 2'h1,
      OTP_MODE_WRITE = 2'h2
   } otp_mode_e;

endpackage

// *** design/otp_crc8.sv ***
`timescale 1ns/100ps
`include "otp_regs.svh"

module otp_crc8 (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic       clr,
   input  wire logic       en,
   input  wire logic       bit_in,
   // result
   output logic [7:0]      crc_r,
   output logic [7:0]      crc_nxt
);

   // -------------------------------------------------------------------------
   // serial shift, x^8 + x^5 + x^4 + 1, lsb first
   // -------------------------------------------------------------------------
   logic       fb;
   logic [7:0] shifted;

   // feedback and next value
   always_comb begin
      fb      = crc_r[0] ^ bit_in;
      shifted = {1'b0, crc_r[7:1]} ^ (fb ? `OTP_CRC_POLY : 8'h00);
      crc_nxt = en ? shifted : crc_r;
   end

   // generator register, clear has priority
   always_ff @(posedge clk) begin
      if (!rst_n || clr) begin
         crc_r <= `OTP_CRC_INIT;
      end else begin
         crc_r <= crc_nxt;
      end
   end

endmodule // otp_crc8

// *** sim/otp_host_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// single-wire host controller, slot level, driven on falling edges
// ----------------------------------------------------------------------------
module otp_host_model (
   // clock
   input  wire logic ref_clk,
   // slot signals towards the engine
   output logic      link_reset,
   output logic      bit_strobe,
   output logic      bit_in,
   output logic      prog_pulse,
   // answer from the engine
   input  wire logic data_out
);
   // idle line levels at time zero
   initial begin
      link_reset = 1'b0;
      bit_strobe = 1'b0;
      bit_in     = 1'b1;
      prog_pulse = 1'b0;
   end

   // reset pulse, then sit out the answer pulse
   task automatic bus_reset();
      @(negedge ref_clk);
      link_reset = 1'b1;
      @(negedge ref_clk);
      link_reset = 1'b0;
      repeat (3100) @(negedge ref_clk);
   endtask

   // eight write slots, bit_in flips away from the last bit between slots
   task automatic put_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         bit_strobe = 1'b1;
         bit_in     = b[i];
         @(negedge ref_clk);
         bit_strobe = 1'b0;
         bit_in     = ~b[i];
      end
   endtask

   // eight read slots, bit taken before the slot consumes it
   task automatic get_byte(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(negedge ref_clk);
         b[i]       = data_out;
         bit_strobe = 1'b1;
         @(negedge ref_clk);
         bit_strobe = 1'b0;
      end
   endtask

   // programming pulse; mid_rst throws a reset into it on purpose
   task automatic pulse_prog(input int n, input bit mid_rst);
      @(negedge ref_clk);
      prog_pulse = 1'b1;
      repeat (n / 2) @(negedge ref_clk);
      link_reset = mid_rst;
      @(negedge ref_clk);
      link_reset = 1'b0;
      repeat (n / 2) @(negedge ref_clk);
      prog_pulse = 1'b0;
      repeat (2) @(negedge ref_clk);
   endtask
endmodule // otp_host_model

// *** sim/otp_cmd_engine_assertions.sv ***
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// port level checker for the command engine
// ----------------------------------------------------------------------------
module otp_cmd_engine_assertions #(
   parameter int unsigned MEM_BYTES  = 128,
   parameter int unsigned PAGE_BYTES = 32
) (
   // clock and reset
   input  wire logic                            ref_clk,
   input  wire logic                            rst_n,
   // slot front end
   input  wire logic                            link_reset,
   input  wire logic                            bit_strobe,
   input  wire logic                            bit_in,
   input  wire logic                            prog_pulse,
   input  wire logic [MEM_BYTES/PAGE_BYTES-1:0] page_wp,
   // answers
   input  wire logic                            data_out,
   input  wire logic                            device_answer_pulse
);
   logic        seen_r;
   logic        ev1_r;
   logic        ev2_r;
   logic [15:0] ans_cnt_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // first link reset seen since rst_n
   always_ff @(posedge ref_clk) begin
      if (!rst_n) seen_r <= 1'b0;
      else if (link_reset) seen_r <= 1'b1;
   end

   // slot events of the last two cycles, the only causes of a data_out change
   always_ff @(posedge ref_clk) begin
      ev1_r <= bit_strobe | link_reset | prog_pulse;
      ev2_r <= ev1_r;
   end

   // length of the running answer pulse
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !device_answer_pulse) ans_cnt_r <= 16'h0000;
      else ans_cnt_r <= ans_cnt_r + 16'h0001;
   end

   ans_start_a: assert property (link_reset && !prog_pulse |=> ##[0:2] device_answer_pulse)
      else $error("answer pulse did not follow link reset");
   ans_cause_a: assert property ($rose(device_answer_pulse)
      |-> $past(link_reset) || $past(link_reset, 2) || $past(link_reset, 3))
      else $error("answer pulse without a link reset");
   ans_hold_a: assert property ($rose(device_answer_pulse) |-> device_answer_pulse[*8])
      else $error("answer pulse too short");
   ans_len_a: assert property ($fell(device_answer_pulse) && !$past(link_reset) |-> ans_cnt_r == 16'hbb8)
      else $error("answer pulse length wrong");
   quiet_idle_a: assert property (!seen_r |-> !device_answer_pulse && data_out)
      else $error("engine answered before any link reset");
   out_stable_a: assert property (!ev1_r && !ev2_r |-> $stable(data_out))
      else $error("data_out changed without a slot");
   prog_reset_a: assert property (prog_pulse && link_reset |=> !device_answer_pulse[*3])
      else $error("link reset taken during program pulse");
   ans_drop_a: assert property (link_reset && !prog_pulse |=> !device_answer_pulse)
      else $error("answer pulse high while link reset");

   cover property ($rose(device_answer_pulse));
   cover property (prog_pulse && link_reset);
   cover property ($fell(prog_pulse) ##[1:40] bit_strobe);
endmodule // otp_cmd_engine_assertions

bind otp_cmd_engine otp_cmd_engine_assertions #(.MEM_BYTES(MEM_BYTES), .PAGE_BYTES(PAGE_BYTES)) i_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .link_reset(link_reset), .bit_strobe(bit_strobe), .bit_in(bit_in),
   .prog_pulse(prog_pulse), .page_wp(page_wp), .data_out(data_out), .device_answer_pulse(device_answer_pulse));

// *** sim/tb_top.sv ***
`timescale 1ns/100ps

module tb_top
   import otp_pkg::*;
;
   typedef struct {logic [7:0] cmd; logic [7:0] lo; logic [7:0] hi; logic [3:0] wp; logic [63:0] dat;} otp_row_s;
   localparam int unsigned PROG_N = 20;
   logic       ref_clk;
   logic       rst_n;
   logic       link_reset;
   logic       bit_strobe;
   logic       bit_in;
   logic       prog_pulse;
   logic [3:0] page_wp;
   logic       data_out;
   logic       device_answer_pulse;
   logic [7:0] mem_m [128];
   otp_row_s   rows [7];
   int         fail_count;
   int         comparisons;

   // -------------------------------------------------------------------------
   // design, host and clock
   // -------------------------------------------------------------------------
   otp_cmd_engine #(.PROG_CYC(PROG_N)) i_otp_cmd_engine (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_reset(link_reset), .bit_strobe(bit_strobe), .bit_in(bit_in),
      .prog_pulse(prog_pulse), .page_wp(page_wp), .data_out(data_out), .device_answer_pulse(device_answer_pulse));
   otp_host_model i_otp_host_model (
      .ref_clk(ref_clk), .link_reset(link_reset), .bit_strobe(bit_strobe), .bit_in(bit_in),
      .prog_pulse(prog_pulse), .data_out(data_out));

   always #20 ref_clk = ~ref_clk;

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   function automatic logic [7:0] crc_upd(input logic [7:0] c, input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         c = (c[0] ^ b[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
      end
      return c;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // reset, skip-id, command and address, then the address crc
   task automatic start_cmd(input logic [7:0] cmd, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0] b;
      i_otp_host_model.bus_reset();
      i_otp_host_model.put_byte(8'hcc);
      i_otp_host_model.put_byte(cmd);
      i_otp_host_model.put_byte(lo);
      i_otp_host_model.put_byte(hi);
      i_otp_host_model.get_byte(b);
      check(b, crc_upd(crc_upd(crc_upd(8'h00, cmd), lo), hi));
   endtask

   // read to the end of memory, crc per page or once at the end, then ones
   task automatic read_rest(input logic [6:0] a, input bit page);
      logic [7:0] c;
      logic [7:0] b;
      c = 8'h00;
      for (int k = a; k < 128; k++) begin
         i_otp_host_model.get_byte(b);
         check(b, mem_m[k]);
         c = crc_upd(c, mem_m[k]);
         if ((page && k % 32 == 31) || k == 127) begin
            i_otp_host_model.get_byte(b);
            check(b, c);
            c = 8'h00;
         end
      end
      i_otp_host_model.get_byte(b);
      check(b, 8'hff);
   endtask

   // whole write sequence with programming and read-back
   task automatic wr(input logic [7:0] lo, input logic [7:0] hi, input logic [63:0] d, input bit mid_rst);
      logic [7:0] c;
      logic [7:0] b;
      logic [6:0] seg;
      c   = 8'h00;
      seg = {lo[6:3], 3'b000};
      start_cmd(8'h0f, lo, hi);
      for (int i = 0; i < 8; i++) begin
         i_otp_host_model.put_byte(d[8*i +: 8]);
         c = crc_upd(c, d[8*i +: 8]);
         if (!page_wp[seg[6:5]]) mem_m[seg + i] = mem_m[seg + i] & d[8*i +: 8];
      end
      i_otp_host_model.get_byte(b);
      check(b, c);
      i_otp_host_model.put_byte(8'h5a);
      i_otp_host_model.pulse_prog(PROG_N + 4, mid_rst);
      i_otp_host_model.get_byte(b);
      check(b, mem_m[seg]);
      i_otp_host_model.get_byte(b);
      check(b, 8'hff);
   endtask

   // -------------------------------------------------------------------------
   // watchdog
   // -------------------------------------------------------------------------
   initial begin
      #(40 * 90000);
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      report_and_stop();
   end

   // -------------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------------
   initial begin
      logic [7:0] b;
      ref_clk     = 1'b0;
      rst_n       = 1'b0;
      page_wp     = 4'h0;
      fail_count  = 0;
      comparisons = 0;
      for (int i = 0; i < 128; i++) mem_m[i] = 8'hff;
      rows[0] = '{8'h0f, 8'h23, 8'h00, 4'h0, 64'h0123456789abcdef};
      rows[1] = '{8'h0f, 8'h68, 8'h00, 4'h8, 64'h0000000000000000};
      rows[2] = '{8'h0f, 8'ha0, 8'h11, 4'h0, 64'hf0f0f0f00f0f0f0f};
      rows[3] = '{8'hc3, 8'h1e, 8'h00, 4'h0, 64'h0};
      rows[4] = '{8'hc3, 8'h7e, 8'h00, 4'h0, 64'h0};
      rows[5] = '{8'hf0, 8'h9f, 8'h5a, 4'h0, 64'h0};
      rows[6] = '{8'hf0, 8'h60, 8'h00, 4'h8, 64'h0};
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      // table of ordinary sequences
      for (int r = 0; r < 7; r++) begin
         @(negedge ref_clk);
         page_wp = rows[r].wp;
         if (rows[r].cmd == 8'h0f) wr(rows[r].lo, rows[r].hi, rows[r].dat, 1'b0);
         else begin
            start_cmd(rows[r].cmd, rows[r].lo, rows[r].hi);
            read_rest(rows[r].lo[6:0], rows[r].cmd == 8'hc3);
         end
      end
      // memory command without the skip-id byte is not taken
      i_otp_host_model.bus_reset();
      i_otp_host_model.put_byte(8'hc3);
      i_otp_host_model.put_byte(8'h1e);
      i_otp_host_model.put_byte(8'h00);
      i_otp_host_model.get_byte(b);
      check(b, 8'hff);
      // aborted field read, then a fresh one sees a clean crc
      start_cmd(8'hf0, 8'h20, 8'h00);
      i_otp_host_model.get_byte(b);
      check(b, mem_m[32]);
      start_cmd(8'hf0, 8'h7f, 8'h00);
      read_rest(7'h7f, 1'b0);
      // link reset thrown into the programming pulse is ignored
      wr(8'h00, 8'h00, 64'h55aa33cc0ff0a55a, 1'b1);
      start_cmd(8'hf0, 8'h00, 8'h00);
      read_rest(7'h00, 1'b0);
      // reset in mid read releases the line and restores erased memory
      start_cmd(8'hc3, 8'h00, 8'h00);
      i_otp_host_model.get_byte(b);
      @(negedge ref_clk);
      rst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      check({7'h00, data_out}, 8'h01);
      rst_n = 1'b1;
      for (int i = 0; i < 128; i++) mem_m[i] = 8'hff;
      start_cmd(8'hc3, 8'h7e, 8'h00);
      read_rest(7'h7e, 1'b1);
      report_and_stop();
   end
endmodule // tb_top
